// >>> rtl/css_selector.sv
`timescale 1ns/1ps
`include "css_map.svh"
module css_selector
  import css_pkg::*;
#(
  parameter int FW = 16,
  parameter int NT = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NT-1:0] term_pin,
  input wire logic keypad_run_key,
  input wire logic keypad_stop_key,
  input wire logic remote_takeover_key,
  input wire logic panel_fitted,
  input wire logic fieldbus_fitted,
  input wire logic [7:0] fieldbus_run_src,
  input wire css_run_cmd_t remote_cmd,
  input wire css_run_cmd_t serial_cmd,
  input wire css_run_cmd_t opt1_cmd,
  input wire css_run_cmd_t opt2_cmd,
  input wire logic [FW-1:0] analog_freq,
  input wire logic [FW-1:0] knob_freq,
  input wire logic [FW-1:0] remote_freq,
  input wire logic [FW-1:0] serial_freq,
  input wire logic [FW-1:0] opt1_freq,
  input wire logic [FW-1:0] pulse_freq,
  input wire logic [FW-1:0] seq_freq,
  input wire logic [FW-1:0] loop_feedback,
  output css_drive_t drive_cmd,
  output logic [FW-1:0] drive_freq,
  output logic restrict_ind,
  output logic conflict_stop
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0] fsrc_q, rsrc_q;
  logic kdir_q;
  logic [1:0] drest_q;
  logic [NT-1:0] pol_q;
  logic [15:0] force_q;
  logic [FW-1:0] kfreq_q, fstart_q, fmax_q, fbpct_q;
  logic [2:0][FW-1:0] step_q;
  logic [NT-1:0][7:0] tfn_q;
  logic remote_q, kp_run_q, manual_q;
  logic [NT-1:0] pin_s1_q, pin_s2_q;
  logic aw_full_q, w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  css_drive_t drive_q;
  logic [FW-1:0] freq_q;
  logic restr_q, confl_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : hit
  function automatic logic fn_on(input logic [7:0] code,
                                 input logic [NT-1:0] act,
                                 input logic [NT-1:0][7:0] fns);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NT; i++) begin
      r = r | (act[i] && fns[i] == code);
    end
    return r;
  endfunction : fn_on
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  // ****************************************
  // terminal inputs
  // ****************************************
  logic [NT-1:0] term_act;
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_term
      assign term_act[gi] = pin_s2_q[gi] ^ pol_q[gi];
    end
  endgenerate
  wire t_fwd = fn_on(`CSS_FN_FWD, term_act, tfn_q);
  wire t_rev = fn_on(`CSS_FN_REV, term_act, tfn_q);
  wire set2 = fn_on(`CSS_FN_SET2, term_act, tfn_q);
  wire third_set_select = fn_on(`CSS_FN_THIRD_SET_SELECT, term_act, tfn_q);
  wire force_on = fn_on(`CSS_FN_FORCE, term_act, tfn_q)
                | fn_on(`CSS_FN_FORCE_T, term_act, tfn_q);
  // ****************************************
  // source selection
  // ****************************************
  wire [7:0] eff_fsrc = force_on ? force_q[7:0]
                      : remote_q ? `CSS_SRC_KEYPAD : fsrc_q;
  wire [7:0] eff_rsrc = force_on ? force_q[15:8]
                      : remote_q ? `CSS_SRC_KEYPAD
                      : (fieldbus_fitted && !manual_q) ? fieldbus_run_src
                      : rsrc_q;
  wire kp_mode = eff_rsrc == `CSS_SRC_KEYPAD && !remote_q;
  css_run_cmd_t kp_cmd, req;
  assign kp_cmd = kp_run_q ? (kdir_q ? 2'b01 : 2'b10) : 2'b00;
  assign req = eff_rsrc == `CSS_RS_TERM ? css_run_cmd_t'({t_fwd, t_rev})
             : eff_rsrc == `CSS_SRC_KEYPAD ? (remote_q ? remote_cmd : kp_cmd)
             : eff_rsrc == `CSS_RS_SERIAL ? serial_cmd
             : eff_rsrc == `CSS_RS_OPT1 ? opt1_cmd
             : eff_rsrc == `CSS_RS_OPT2 ? opt2_cmd
             : 2'b00;
  wire confl = req.fwd & req.rev;
  wire run_req = req.fwd ^ req.rev;
  wire ana_neg = analog_freq[FW-1];
  wire [FW-1:0] ana_mag = ana_neg ? FW'(-analog_freq) : analog_freq;
  wire ana_inv = eff_fsrc == `CSS_FS_ANALOG && ana_neg;
  wire fin_rev = req.rev ^ ana_inv;
  wire [FW-1:0] kp_freq = remote_q ? remote_freq : kfreq_q;
  wire [FW-1:0] freq_sel =
      eff_fsrc == `CSS_FS_KNOB ? (panel_fitted ? knob_freq : '0)
    : eff_fsrc == `CSS_FS_ANALOG ? ana_mag
    : eff_fsrc == `CSS_SRC_KEYPAD ? kp_freq
    : eff_fsrc == `CSS_FS_SERIAL ? serial_freq
    : eff_fsrc == `CSS_FS_OPT1 ? opt1_freq
    : eff_fsrc == `CSS_FS_PULSE ? pulse_freq
    : eff_fsrc == `CSS_FS_SEQ ? seq_freq
    : '0;
  wire restricted = (drest_q == `CSS_DR_FWD && fin_rev)
                  || (drest_q == `CSS_DR_REV && !fin_rev);
  wire block = run_req && restricted;
  // ****************************************
  // register bus
  // ****************************************
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
  wire aw_full_d = do_wr ? 1'b0 : aw_full_q | aw_take;
  wire w_full_d = do_wr ? 1'b0 : w_full_q | w_take;
  wire rvalid_d = ar_take | (s_axi_rvalid && !s_axi_rready);
  function automatic logic mapped(input logic [7:0] a);
    return a[7:2] <= `CSS_OFF_FBPCT >> 2
        || (a[7:2] >= `CSS_OFF_TFN0 >> 2 && a[7:2] < (`CSS_OFF_TFN0 >> 2) + NT);
  endfunction : mapped
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] r;
    logic [5:0] ti;
    r = '0;
    ti = a[7:2] - 6'(`CSS_OFF_TFN0 >> 2);
    if (hit(a, `CSS_OFF_FSRC)) r[7:0] = fsrc_q;
    if (hit(a, `CSS_OFF_RSRC)) r[7:0] = rsrc_q;
    if (hit(a, `CSS_OFF_KDIR)) r[0] = kdir_q;
    if (hit(a, `CSS_OFF_DREST)) r[1:0] = drest_q;
    if (hit(a, `CSS_OFF_POL)) r[NT-1:0] = pol_q;
    if (hit(a, `CSS_OFF_FORCE)) r[15:0] = force_q;
    // monitor of the active command when keypad is not the source
    if (hit(a, `CSS_OFF_KFREQ)) r[FW-1:0] = eff_fsrc == `CSS_SRC_KEYPAD ? kfreq_q : freq_q;
    for (int s = 0; s < 3; s++) begin
      if (a[7:2] == 6'((`CSS_OFF_STEP0 >> 2) + s)) r[FW-1:0] = step_q[s];
    end
    if (hit(a, `CSS_OFF_FSTART)) r[FW-1:0] = fstart_q;
    if (hit(a, `CSS_OFF_FMAX)) r[FW-1:0] = fmax_q;
    if (hit(a, `CSS_OFF_STATUS)) begin
      r[`CSS_ST_RUN] = drive_q.run;
      r[`CSS_ST_REV] = drive_q.reverse;
      r[`CSS_ST_RESTR] = restr_q;
      r[`CSS_ST_CONFL] = confl_q;
      r[`CSS_ST_REMOTE] = remote_q;
      r[`CSS_ST_FORCE] = force_on;
      r[`CSS_ST_RSRC +: 8] = eff_rsrc;
      r[`CSS_ST_FSRC +: 8] = eff_fsrc;
    end
    if (hit(a, `CSS_OFF_FBPCT)) r[FW-1:0] = fbpct_q;
    if (ti < 6'(NT)) r[7:0] = tfn_q[ti[2:0]];
    return r;
  endfunction : rd_mux

  // always_comb so the old-value read follows every register that rd_mux reads
  logic [31:0] wval;
  always_comb wval = merge(rd_mux(aw_addr_q), w_data_q, w_strb_q);
  wire [FW-1:0] wf = wval[FW-1:0];
  wire step_ok = wf == '0 || (wf >= fstart_q && wf <= fmax_q);
  wire kf_wr = do_wr && hit(aw_addr_q, `CSS_OFF_KFREQ);
  wire kf_ok = kf_wr && eff_fsrc == `CSS_SRC_KEYPAD && step_ok;
  wire [1:0] set_idx = third_set_select ? 2'd2 : set2 ? 2'd1 : 2'd0;
  wire rs_wr = do_wr && hit(aw_addr_q, `CSS_OFF_RSRC);
  wire rs_ok = !fieldbus_fitted || (wval[7:0] >= `CSS_RS_TERM
                                 && wval[7:0] <= `CSS_RS_SERIAL);
  wire [5:0] wti = aw_addr_q[7:2] - 6'(`CSS_OFF_TFN0 >> 2);
  wire [31:0] fb_prod = 32'(loop_feedback) * `CSS_PCT_FULL;
  wire [FW-1:0] fb_pct = fmax_q == '0 ? '0 : FW'(fb_prod / 32'(fmax_q));

  // ****************************************
  // bus handshake
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSS_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CSS_RESP_OK;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      s_axi_awready <= !aw_full_d;
      s_axi_wready <= !w_full_d;
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_q) ? `CSS_RESP_OK : `CSS_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_take) begin
        s_axi_rdata <= mapped(s_axi_araddr) ? rd_mux(s_axi_araddr) : '0;
        s_axi_rresp <= mapped(s_axi_araddr) ? `CSS_RESP_OK : `CSS_RESP_ERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_take) aw_addr_q <= s_axi_awaddr;
    if (w_take) begin
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fsrc_q <= `CSS_RST_FSRC;
      rsrc_q <= `CSS_RST_RSRC;
      kdir_q <= 1'b0;
      drest_q <= `CSS_DR_BOTH;
      pol_q <= '0;
      force_q <= `CSS_RST_FORCE;
      fstart_q <= `CSS_RST_FSTART;
      fmax_q <= `CSS_RST_FMAX;
      kfreq_q <= '0;
      step_q <= '0;
      manual_q <= 1'b0;
      for (int i = 0; i < NT; i++) begin
        tfn_q[i] <= `CSS_FN_NONE;
      end
      tfn_q[`CSS_FWD_TERM] <= `CSS_FN_FWD;
    end else begin
      if (do_wr && hit(aw_addr_q, `CSS_OFF_FSRC)) fsrc_q <= wval[7:0];
      if (rs_wr && rs_ok) begin
        rsrc_q <= wval[7:0];
        manual_q <= 1'b1;
      end
      if (do_wr && hit(aw_addr_q, `CSS_OFF_KDIR)) kdir_q <= wval[0];
      if (do_wr && hit(aw_addr_q, `CSS_OFF_DREST)) drest_q <= wval[1:0];
      if (do_wr && hit(aw_addr_q, `CSS_OFF_POL)) pol_q <= wval[NT-1:0];
      if (do_wr && hit(aw_addr_q, `CSS_OFF_FORCE)) force_q <= wval[15:0];
      if (do_wr && hit(aw_addr_q, `CSS_OFF_FSTART)) fstart_q <= wf;
      if (do_wr && hit(aw_addr_q, `CSS_OFF_FMAX)) fmax_q <= wf;
      for (int s = 0; s < 3; s++) begin
        if (do_wr && step_ok && aw_addr_q[7:2] == 6'((`CSS_OFF_STEP0 >> 2) + s)) begin
          step_q[s] <= wf;
        end
      end
      if (kf_ok) begin
        kfreq_q <= wf;
        step_q[set_idx] <= wf;
      end
      if (do_wr && wti < 6'(NT)) tfn_q[wti[2:0]] <= wval[7:0];
    end
  end

  // ****************************************
  // command state and outputs
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      remote_q <= 1'b0;
      kp_run_q <= 1'b0;
      drive_q <= '0;
      freq_q <= '0;
      restr_q <= 1'b0;
      confl_q <= 1'b0;
      fbpct_q <= '0;
    end else begin
      pin_s1_q <= term_pin;
      pin_s2_q <= pin_s1_q;
      // software handing the run source back ends a takeover
      if (remote_takeover_key) remote_q <= 1'b1;
      else if (rs_wr) remote_q <= 1'b0;
      if (!kp_mode || keypad_stop_key) kp_run_q <= 1'b0;
      else if (keypad_run_key) kp_run_q <= 1'b1;
      drive_q.run <= run_req && !block;
      drive_q.reverse <= run_req && !block && fin_rev;
      freq_q <= freq_sel;
      restr_q <= block;
      confl_q <= confl;
      fbpct_q <= fb_pct;
    end
  end

  assign drive_cmd = drive_q;
  assign drive_freq = freq_q;
  assign restrict_ind = restr_q;
  assign conflict_stop = confl_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_conflict_stop: assert property (confl |=> !drive_q.run && confl_q)
    else $error("conflicting run request did not stop");
  a_fwd_only: assert property (drive_q.run && drive_q.reverse |-> $past(drest_q) != `CSS_DR_FWD)
    else $error("reverse run under forward only restriction");
  a_rev_only: assert property (drive_q.run && !drive_q.reverse |-> $past(drest_q) != `CSS_DR_REV)
    else $error("forward run under reverse only restriction");
  a_restrict_show: assert property (block |=> restr_q && !drive_q.run)
    else $error("restricted request not indicated");
  a_kfreq_guard: assert property (kf_wr && eff_fsrc != `CSS_SRC_KEYPAD |=> $stable(kfreq_q))
    else $error("keypad frequency written while not selected");
  a_step_copy: assert property (kf_ok && set_idx == 2'd1 |=> step_q[1] == $past(wf))
    else $error("second set step zero not updated");
  a_unsup_src: assert property (!(eff_rsrc inside {[`CSS_RS_TERM:`CSS_RS_OPT2]}) |=> !drive_q.run)
    else $error("run from unsupported source");
  a_keypad_dir: assert property (kp_mode && kp_run_q && !ana_inv && !block
                                 |=> drive_q.run && drive_q.reverse == $past(kdir_q))
    else $error("keypad run direction wrong");
  a_remote_both: assert property ($rose(remote_q) |-> eff_rsrc == `CSS_SRC_KEYPAD
                                  && eff_fsrc == `CSS_SRC_KEYPAD)
    else $error("takeover did not move both sources");
  a_analog_inv: assert property (ana_inv && run_req && !block |=> drive_q.reverse == !$past(req.rev))
    else $error("negative analogue command did not invert");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  c_conflict: cover property (confl ##1 confl_q);
  c_restrict: cover property ($rose(restr_q));
  c_takeover: cover property (remote_takeover_key ##1 remote_q);
  c_force: cover property (force_on && drive_q.run);
endmodule : css_selector

// >>> common/css_map.svh
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define CSS_OFF_FSRC 8'h00
`define CSS_OFF_RSRC 8'h04
`define CSS_OFF_KDIR 8'h08
`define CSS_OFF_DREST 8'h0c
`define CSS_OFF_POL 8'h10
`define CSS_OFF_FORCE 8'h14
`define CSS_OFF_KFREQ 8'h18
`define CSS_OFF_STEP0 8'h1c
`define CSS_OFF_FSTART 8'h28
`define CSS_OFF_FMAX 8'h2c
`define CSS_OFF_STATUS 8'h30
`define CSS_OFF_FBPCT 8'h34
`define CSS_OFF_TFN0 8'h40
// ****************************************
// source and function codes
// ****************************************
`define CSS_FS_KNOB 8'h00
`define CSS_FS_ANALOG 8'h01
`define CSS_SRC_KEYPAD 8'h02
`define CSS_FS_SERIAL 8'h03
`define CSS_FS_OPT1 8'h04
`define CSS_FS_PULSE 8'h06
`define CSS_FS_SEQ 8'h07
`define CSS_RS_TERM 8'h01
`define CSS_RS_SERIAL 8'h03
`define CSS_RS_OPT1 8'h04
`define CSS_RS_OPT2 8'h05
`define CSS_DR_BOTH 2'h0
`define CSS_DR_FWD 2'h1
`define CSS_DR_REV 2'h2
`define CSS_FN_FWD 8'h00
`define CSS_FN_REV 8'h01
`define CSS_FN_SET2 8'h08
`define CSS_FN_THIRD_SET_SELECT 8'h11
`define CSS_FN_FORCE 8'h1f
`define CSS_FN_FORCE_T 8'h33
`define CSS_FN_NONE 8'hff
// ****************************************
// reset values and status fields
// ****************************************
`define CSS_RST_FSRC 8'h02
`define CSS_RST_RSRC 8'h02
`define CSS_RST_FORCE 16'h0101
`define CSS_RST_FSTART 16'h0032
`define CSS_RST_FMAX 16'h1770
`define CSS_FWD_TERM 3'h7
`define CSS_PCT_FULL 32'h0000_0064
`define CSS_ST_RUN 0
`define CSS_ST_REV 1
`define CSS_ST_RESTR 2
`define CSS_ST_CONFL 3
`define CSS_ST_REMOTE 4
`define CSS_ST_FORCE 5
`define CSS_ST_RSRC 8
`define CSS_ST_FSRC 16
`define CSS_RESP_OK 2'h0
`define CSS_RESP_ERR 2'h2
`endif

// >>> common/css_pkg.sv
package css_pkg;
  // ****************************************
  // command carriers
  // ****************************************
  typedef struct packed {
    logic fwd;
    logic rev;
  } css_run_cmd_t;

  typedef struct packed {
    logic run;
    logic reverse;
  } css_drive_t;
endpackage : css_pkg

// >>> sim/css_src_model.sv
`timescale 1ns/1ps
// ****************************************
// far-side command sources
// ****************************************
module css_src_model
  import css_pkg::*;
(
  input wire logic [7:0] run_sel,
  input wire logic [7:0] freq_sel,
  input wire logic fwd,
  input wire logic rev,
  input wire logic [2:0] aux,
  input wire logic [7:0] pol,
  input wire logic [15:0] freq,
  output logic [7:0] term_pin,
  output css_run_cmd_t remote_cmd,
  output css_run_cmd_t serial_cmd,
  output css_run_cmd_t opt1_cmd,
  output css_run_cmd_t opt2_cmd,
  output logic [15:0] analog_freq,
  output logic [15:0] knob_freq,
  output logic [15:0] remote_freq,
  output logic [15:0] serial_freq,
  output logic [15:0] opt1_freq,
  output logic [15:0] pulse_freq,
  output logic [15:0] seq_freq
);
  css_run_cmd_t req;
  css_run_cmd_t idle;
  assign req = {fwd, rev};
  // unselected remote, serial and option sources show the opposite request so a wrong pick is visible
  assign idle = ~req;
  // contact closed is active at polarity bit 0, open at 1
  assign term_pin = {run_sel == 8'h01 && fwd, 3'h0, aux, run_sel == 8'h01 && rev} ^ pol;
  assign remote_cmd = (run_sel == 8'h02) ? req : idle;
  assign serial_cmd = (run_sel == 8'h03) ? req : idle;
  assign opt1_cmd = (run_sel == 8'h04) ? req : idle;
  assign opt2_cmd = (run_sel == 8'h05) ? req : idle;
  assign knob_freq = (freq_sel == 8'h00) ? freq : ~freq;
  assign analog_freq = (freq_sel == 8'h01) ? freq : ~freq;
  assign remote_freq = (freq_sel == 8'h02) ? freq : ~freq;
  assign serial_freq = (freq_sel == 8'h03) ? freq : ~freq;
  assign opt1_freq = (freq_sel == 8'h04) ? freq : ~freq;
  assign pulse_freq = (freq_sel == 8'h06) ? freq : ~freq;
  assign seq_freq = (freq_sel == 8'h07) ? freq : ~freq;
endmodule : css_src_model

// >>> sim/command_source_selector_tb_top.sv
`timescale 1ns/1ps
`include "css_map.svh"
module command_source_selector_tb_top
  import css_pkg::*;
();
  typedef struct {
    logic [7:0] rs;
    logic [7:0] fs;
    logic [1:0] dr;
    logic f;
    logic r;
    logic [3:0] x;
    logic [15:0] q;
  } css_row_t;
  // run src, freq src, restriction, fwd, rev, {run, reverse, restrict, conflict}, freq
  css_row_t rows[8] = '{
    '{8'h03, 8'h03, 2'h0, 1'b1, 1'b0, 4'b1000, 16'h0123},
    '{8'h04, 8'h04, 2'h0, 1'b0, 1'b1, 4'b1100, 16'h0123},
    '{8'h05, 8'h06, 2'h1, 1'b0, 1'b1, 4'b0010, 16'h0123},
    '{8'h03, 8'h07, 2'h2, 1'b1, 1'b0, 4'b0010, 16'h0123},
    '{8'h01, 8'h01, 2'h0, 1'b1, 1'b0, 4'b1000, 16'h0123},
    '{8'h01, 8'h01, 2'h0, 1'b1, 1'b1, 4'b0001, 16'h0123},
    '{8'h06, 8'h05, 2'h0, 1'b1, 1'b0, 4'b0000, 16'h0000},
    '{8'h05, 8'h03, 2'h2, 1'b0, 1'b1, 4'b1100, 16'h0123}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fieldbus_run_src = 8'h00;
  logic [7:0] p_rs = 8'h02, p_fs = 8'h02, p_pol = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, panel_fitted = 1'b0, fieldbus_fitted = 1'b0;
  logic keypad_run_key = 1'b0, keypad_stop_key = 1'b0, remote_takeover_key = 1'b0, p_f = 1'b0, p_r = 1'b0;
  logic [2:0] p_aux = 3'h0;
  logic [15:0] p_fq = 16'h0123, loop_feedback = 16'h0bb8;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, restrict_ind, conflict_stop;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] term_pin;
  logic [15:0] drive_freq, analog_freq, knob_freq, remote_freq, serial_freq, opt1_freq, pulse_freq, seq_freq;
  css_drive_t drive_cmd;
  css_run_cmd_t remote_cmd, serial_cmd, opt1_cmd, opt2_cmd;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;

  css_selector dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .term_pin,
    .keypad_run_key, .keypad_stop_key, .remote_takeover_key, .panel_fitted, .fieldbus_fitted,
    .fieldbus_run_src, .remote_cmd, .serial_cmd, .opt1_cmd, .opt2_cmd, .analog_freq, .knob_freq,
    .remote_freq, .serial_freq, .opt1_freq, .pulse_freq, .seq_freq, .loop_feedback, .drive_cmd,
    .drive_freq, .restrict_ind, .conflict_stop);
  css_src_model src_u (.run_sel(p_rs), .freq_sel(p_fs), .fwd(p_f), .rev(p_r), .aux(p_aux), .pol(p_pol),
    .freq(p_fq), .term_pin, .remote_cmd, .serial_cmd, .opt1_cmd, .opt2_cmd, .analog_freq, .knob_freq,
    .remote_freq, .serial_freq, .opt1_freq, .pulse_freq, .seq_freq);

  always #12.5 aclk = ~aclk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ****************************************
  // register bus master
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, x);
    chk(s_axi_rresp, e);
  endtask : rdc

  // one-cycle pulse: 0 run key, 1 stop key, 2 takeover key
  task automatic key(input int k);
    {remote_takeover_key, keypad_stop_key, keypad_run_key} <= 3'b001 << k;
    @(posedge aclk);
    {remote_takeover_key, keypad_stop_key, keypad_run_key} <= 3'b000;
    repeat (3) @(posedge aclk);
  endtask : key

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`CSS_OFF_FSRC, 32'h02);
    rdc(`CSS_OFF_FORCE, 32'h0101);
    rdc(`CSS_OFF_TFN0 + 8'h1c, 32'h00);
    rdc(`CSS_OFF_TFN0, 32'hff);
    rdc(8'h80, 32'h0, `CSS_RESP_ERR);
    wr(8'h80, 32'h1, `CSS_RESP_ERR);
    $display("test reset done");
    wr(`CSS_OFF_TFN0, `CSS_FN_REV);
    for (int i = 0; i < 8; i++) begin
      wr(`CSS_OFF_RSRC, rows[i].rs);
      wr(`CSS_OFF_FSRC, rows[i].fs);
      wr(`CSS_OFF_DREST, rows[i].dr);
      p_rs <= rows[i].rs;
      p_fs <= rows[i].fs;
      p_f <= rows[i].f;
      p_r <= rows[i].r;
      repeat (6) @(posedge aclk);
      chk({drive_cmd, restrict_ind, conflict_stop}, rows[i].x);
      chk(drive_freq, rows[i].q);
    end
    $display("test table done");
    wr(`CSS_OFF_DREST, 32'h0);
    wr(`CSS_OFF_RSRC, 32'h02);
    wr(`CSS_OFF_FSRC, 32'h02);
    wr(`CSS_OFF_KDIR, 32'h1);
    key(0);
    chk(drive_cmd, 2'b11);
    key(1);
    chk(drive_cmd, 2'b00);
    wr(`CSS_OFF_KDIR, 32'h0);
    key(0);
    chk(drive_cmd, 2'b10);
    wr(`CSS_OFF_KFREQ, 32'h0100);
    repeat (2) @(posedge aclk);
    chk(drive_freq, 16'h0100);
    rdc(`CSS_OFF_STEP0, 32'h0100);
    wr(`CSS_OFF_KFREQ, 32'h0010);
    rdc(`CSS_OFF_STEP0, 32'h0100);
    wr(`CSS_OFF_KFREQ, 32'h0);
    rdc(`CSS_OFF_STEP0, 32'h0);
    wr(`CSS_OFF_TFN0 + 8'h04, `CSS_FN_SET2);
    wr(`CSS_OFF_TFN0 + 8'h08, `CSS_FN_THIRD_SET_SELECT);
    for (int k = 1; k < 3; k++) begin
      p_aux <= 3'(k);
      repeat (4) @(posedge aclk);
      wr(`CSS_OFF_KFREQ, 32'h0100 * k);
      rdc(`CSS_OFF_STEP0 + 8'(4 * k), 32'h0100 * k);
    end
    rdc(`CSS_OFF_STEP0, 32'h0);
    p_aux <= 3'h0;
    wr(`CSS_OFF_FSRC, 32'h03);
    p_fs <= 8'h03;
    wr(`CSS_OFF_KFREQ, 32'h0400);
    rdc(`CSS_OFF_KFREQ, 32'h0123);
    chk(drive_freq, 16'h0123);
    rdc(`CSS_OFF_FBPCT, 32'h32);
    $display("test keypad done");
    wr(`CSS_OFF_RSRC, 32'h03);
    wr(`CSS_OFF_KDIR, 32'h1);
    p_rs <= 8'h02;
    p_fs <= 8'h02;
    p_f <= 1'b1;
    p_r <= 1'b0;
    key(2);
    chk(drive_cmd, 2'b10);
    chk(drive_freq, 16'h0123);
    wr(`CSS_OFF_RSRC, 32'h03);
    repeat (2) @(posedge aclk);
    chk(drive_cmd, 2'b11);
    wr(`CSS_OFF_RSRC, 32'h01);
    wr(`CSS_OFF_FSRC, 32'h01);
    wr(`CSS_OFF_POL, 32'h80);
    p_rs <= 8'h01;
    p_fs <= 8'h01;
    p_pol <= 8'h80;
    repeat (6) @(posedge aclk);
    chk(drive_cmd, 2'b10);
    p_pol <= 8'h00;
    repeat (6) @(posedge aclk);
    chk(drive_cmd, 2'b00);
    wr(`CSS_OFF_POL, 32'h0);
    p_fq <= 16'hff00;
    repeat (6) @(posedge aclk);
    chk(drive_cmd, 2'b11);
    p_fq <= 16'h0123;
    $display("test terminals done");
    wr(`CSS_OFF_RSRC, 32'h03);
    wr(`CSS_OFF_FSRC, 32'h03);
    for (int k = 0; k < 2; k++) begin
      wr(`CSS_OFF_TFN0 + 8'h0c, k ? `CSS_FN_FORCE_T : `CSS_FN_FORCE);
      p_aux <= 3'b100;
      repeat (6) @(posedge aclk);
      chk(drive_cmd, 2'b10);
      chk(drive_freq, 16'h0123);
      p_aux <= 3'h0;
      repeat (6) @(posedge aclk);
      chk(drive_cmd, 2'b11);
    end
    wr(`CSS_OFF_FSRC, 32'h00);
    p_fs <= 8'h00;
    panel_fitted <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(drive_freq, 16'h0123);
    panel_fitted <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(drive_freq, 16'h0000);
    $display("test override done");
    fieldbus_fitted <= 1'b1;
    fieldbus_run_src <= 8'h03;
    aresetn <= 1'b0;
    p_rs <= 8'h03;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(drive_cmd, 2'b10);
    wr(`CSS_OFF_RSRC, 32'h04);
    repeat (2) @(posedge aclk);
    chk(drive_cmd, 2'b10);
    wr(`CSS_OFF_RSRC, 32'h01);
    repeat (6) @(posedge aclk);
    chk(drive_cmd, 2'b00);
    $display("test fieldbus done");
    close_out();
  end
endmodule : command_source_selector_tb_top
